// File: rtl/apsf_defines.vh
// Behaviour
// - control bit 7 selects the fast two-wire bus speed when set
// - control bit 5 picks the impact wake level: zero low, one high
// - settle bit zero gives 370 ms settling, one gives 16 ms
// - control bit 3 set bypasses the antialias low-pass filter
// - control bit 2 set bypasses the drift high-pass filter
// - mode field [1:0]: standby, wake-up, instant-on, full measurement; resets standby
// - writing one to check bit 0 starts a self check; zero clears it
// - check done flag bit 1 and pass flag bit 2 are read-only results
// - writing key 0x52 to the reset register performs a full software reset
// - reading the queue port pops one 16-bit word, high byte first
// - after a pop two reads finish the word; every third read pops again
// - repeated reads of the queue port keep the address fixed
// - reaching the queue port by auto-increment returns zero without popping
// - timebase mode takes the sample rate tick from the clock on interrupt pin a
// - trigger mode makes one sample for each pulse on interrupt pin b
// - timing register 0x3d: bit 1 timebase enable, bit 0 trigger enable
`ifndef APSF_DEFINES_VH
`define APSF_DEFINES_VH
`define APSF_TIMING_OFF 8'h3d
`define APSF_OPCTL_OFF 8'h3f
`define APSF_CHECK_OFF 8'h40
`define APSF_RSTKEY_OFF 8'h41
`define APSF_QUEUE_OFF 8'h42
`define APSF_IRQ_STAT_OFF 8'h50
`define APSF_IRQ_MASK_OFF 8'h51
`define APSF_QFILL_OFF 8'h52
`define APSF_BURST_OFF 8'h53
`define APSF_RESET_KEY 8'h52
`define APSF_OPCTL_MASK 8'hbf
`define APSF_TIMING_MASK 8'h03
`define APSF_CHECK_MASK 8'h01
`define APSF_B_FAST 7
`define APSF_B_WAKE 5
`define APSF_B_SETTLE 4
`define APSF_B_AABYP 3
`define APSF_B_DRBYP 2
`define APSF_B_TBASE 1
`define APSF_B_TRIG 0
`define APSF_B_START 0
`define APSF_B_DONE 1
`define APSF_B_PASS 2
`define APSF_SETTLE_LONG_MS 370
`define APSF_SETTLE_SHORT_MS 16
`define APSF_CLK_HZ 25000000
`define APSF_CHECK_CYC 16'h0040
`define APSF_RESP_OKAY 2'h0
`define APSF_RESP_SLVERR 2'h2
`define APSF_IRQ_W 3
`define APSF_TB_DIV_LAST 8'hff
`define APSF_MODE_MSB 1
`endif

// File: rtl/apsf_ctrl.v
`timescale 1ns/100ps
`include "apsf_defines.vh"
module apsf_ctrl #(
  parameter SETTLE_LONG_CYC = `APSF_SETTLE_LONG_MS * (`APSF_CLK_HZ / 1000),
  parameter SETTLE_SHORT_CYC = `APSF_SETTLE_SHORT_MS * (`APSF_CLK_HZ / 1000),
  parameter QDEPTH = 16,
  parameter QAW = 4,
  parameter CHECK_PASS = 1
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // axi4-lite write address and data
  input wire [8:0] s_axi_awaddr, // four times the index; index 0x53 needs nine bits
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [8:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // external timing pins
  input wire irq_pin_a,
  input wire irq_pin_b,
  // sample source
  input wire [15:0] sample_data,
  // control outputs to the analog side
  output reg fast_bus_speed_sel,
  output reg impact_wake_level_sel,
  output reg antialias_bypass,
  output reg drift_filter_bypass,
  output reg [1:0] op_mode,
  output reg filter_settled,
  output reg sample_strobe,
  output reg irq
);

  // registers
  reg [7:0] opctl_r;
  reg [7:0] timing_r;
  reg check_start_r, check_busy_r, check_complete_flag_r, check_pass_flag_r;
  reg [15:0] check_cnt_r;
  reg [31:0] settle_cnt_r;
  reg [`APSF_IRQ_W-1:0] irq_stat_r, irq_mask_r;
  reg soft_rst_r;
  reg [15:0] qmem [0:QDEPTH-1];
  reg [QAW-1:0] qwr_r, qrd_r;
  reg [QAW:0] qcnt_r;
  reg [15:0] word_r;
  reg [1:0] phase_r;
  reg burst_r;
  reg [7:0] last_rd_r;
  reg overflow_r;
  reg a_s1, a_s2, a_s3, b_s1, b_s2, b_s3;
  reg [7:0] tb_div_r;
  reg have_aw, have_w;
  reg [8:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;

  // byte address to register index
  function [7:0] reg_idx;
    input [8:0] addr;
    begin
      reg_idx = {1'b0, addr[8:2]};
    end
  endfunction

  // pin synchronisers and edge detection
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_s1 <= 1'b0;
      a_s2 <= 1'b0;
      a_s3 <= 1'b0;
      b_s1 <= 1'b0;
      b_s2 <= 1'b0;
      b_s3 <= 1'b0;
    end else begin
      a_s1 <= irq_pin_a;
      a_s2 <= a_s1;
      a_s3 <= a_s2;
      b_s1 <= irq_pin_b;
      b_s2 <= b_s1;
      b_s3 <= b_s2;
    end
  end

  wire a_rise = a_s2 & ~a_s3;
  wire b_rise = b_s2 & ~b_s3;
  wire measuring = (opctl_r[`APSF_MODE_MSB:0] != 2'h0);
  // internal timebase: a rate tick every 256 clocks unless the pin supplies it
  wire tb_tick = timing_r[`APSF_B_TBASE] ? a_rise : (tb_div_r == `APSF_TB_DIV_LAST);
  wire sample_evt = measuring & (timing_r[`APSF_B_TRIG] ? b_rise : tb_tick);

  // write channel decode
  wire wr_go = have_aw & have_w & ~s_axi_bvalid;
  wire [7:0] wr_idx = reg_idx(aw_addr_r);
  wire [7:0] wbyte = w_strb_r[0] ? w_data_r[7:0] : 8'h00;
  wire wr_en = wr_go & w_strb_r[0];
  wire key_hit = wr_en & (wr_idx == `APSF_RSTKEY_OFF) & (wbyte == `APSF_RESET_KEY);

  // read decode
  wire rd_go = s_axi_arvalid & s_axi_arready;
  wire [7:0] rd_idx = reg_idx(s_axi_araddr);
  wire rd_queue = rd_go & (rd_idx == `APSF_QUEUE_OFF);
  // arrival from the previous address counts as auto-increment when burst mode is set
  wire auto_inc = burst_r & (last_rd_r == `APSF_RSTKEY_OFF);
  wire pop = rd_queue & ~auto_inc & (phase_r == 2'h0) & (qcnt_r != {(QAW+1){1'b0}});
  wire push = sample_evt & (qcnt_r != QDEPTH[QAW:0]);
  wire check_evt = check_busy_r & (check_cnt_r == `APSF_CHECK_CYC);

  // axi write handshake, address and data taken in either order
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr_r <= 9'h000;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `APSF_RESP_OKAY;
    end else begin
      s_axi_awready <= ~have_aw & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~have_w & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        have_aw <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        have_w <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (wr_idx)
          `APSF_TIMING_OFF, `APSF_OPCTL_OFF, `APSF_CHECK_OFF, `APSF_RSTKEY_OFF,
          `APSF_IRQ_STAT_OFF, `APSF_IRQ_MASK_OFF, `APSF_BURST_OFF: s_axi_bresp <= `APSF_RESP_OKAY;
          default: s_axi_bresp <= `APSF_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software reset pulse, applied one cycle after the key write
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= key_hit;
    end
  end

  // configuration registers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      opctl_r <= 8'h00;
      timing_r <= 8'h00;
      irq_mask_r <= {`APSF_IRQ_W{1'b0}};
      burst_r <= 1'b0;
    end else if (soft_rst_r) begin
      opctl_r <= 8'h00;
      timing_r <= 8'h00;
      irq_mask_r <= {`APSF_IRQ_W{1'b0}};
      burst_r <= 1'b0;
    end else if (wr_en) begin
      case (wr_idx)
        `APSF_OPCTL_OFF: opctl_r <= wbyte & `APSF_OPCTL_MASK;
        `APSF_TIMING_OFF: timing_r <= wbyte & `APSF_TIMING_MASK;
        `APSF_IRQ_MASK_OFF: irq_mask_r <= wbyte[`APSF_IRQ_W-1:0];
        `APSF_BURST_OFF: burst_r <= wbyte[0];
        default: ;
      endcase
    end
  end

  // self check: a fixed run after the start bit goes high
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      check_start_r <= 1'b0;
      check_busy_r <= 1'b0;
      check_cnt_r <= 16'h0;
      check_complete_flag_r <= 1'b0;
      check_pass_flag_r <= 1'b0;
    end else if (soft_rst_r) begin
      check_start_r <= 1'b0;
      check_busy_r <= 1'b0;
      check_cnt_r <= 16'h0;
      check_complete_flag_r <= 1'b0;
      check_pass_flag_r <= 1'b0;
    end else begin
      if (wr_en & (wr_idx == `APSF_CHECK_OFF)) begin
        check_start_r <= wbyte[`APSF_B_START];
        if (wbyte[`APSF_B_START]) begin
          check_busy_r <= 1'b1;
          check_cnt_r <= 16'h0;
          check_complete_flag_r <= 1'b0;
          check_pass_flag_r <= 1'b0;
        end else begin
          check_busy_r <= 1'b0;
        end
      end else if (check_evt) begin
        check_busy_r <= 1'b0;
        check_complete_flag_r <= 1'b1;
        check_pass_flag_r <= (CHECK_PASS != 0);
      end else if (check_busy_r) begin
        check_cnt_r <= check_cnt_r + 16'h1;
      end
    end
  end

  // settle timer restarts on each leave of standby; length from the settle bit
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt_r <= 32'h0;
      filter_settled <= 1'b0;
    end else if (soft_rst_r | ~measuring) begin
      settle_cnt_r <= 32'h0;
      filter_settled <= 1'b0;
    end else if (!filter_settled) begin
      settle_cnt_r <= settle_cnt_r + 32'h1;
      if (settle_cnt_r + 32'h1 >= (opctl_r[`APSF_B_SETTLE] ? SETTLE_SHORT_CYC : SETTLE_LONG_CYC))
        filter_settled <= 1'b1;
    end
  end

  // timebase divider and sample strobe
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tb_div_r <= 8'h00;
      sample_strobe <= 1'b0;
    end else begin
      tb_div_r <= tb_div_r + 8'h01;
      sample_strobe <= sample_evt;
    end
  end

  // sample queue; the memory holds no reset so it maps to plain storage
  always @(posedge clock) begin
    if (push)
      qmem[qwr_r] <= sample_data;
  end

  // queue pointers and the three-read word sequencer
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      qwr_r <= {QAW{1'b0}};
      qrd_r <= {QAW{1'b0}};
      qcnt_r <= {(QAW+1){1'b0}};
      word_r <= 16'h0;
      phase_r <= 2'h0;
      overflow_r <= 1'b0;
    end else if (soft_rst_r) begin
      qwr_r <= {QAW{1'b0}};
      qrd_r <= {QAW{1'b0}};
      qcnt_r <= {(QAW+1){1'b0}};
      word_r <= 16'h0;
      phase_r <= 2'h0;
      overflow_r <= 1'b0;
    end else begin
      overflow_r <= sample_evt & ~push;
      if (push)
        qwr_r <= qwr_r + {{(QAW-1){1'b0}}, 1'b1};
      if (pop) begin
        qrd_r <= qrd_r + {{(QAW-1){1'b0}}, 1'b1};
        word_r <= qmem[qrd_r];
      end
      if (push & ~pop)
        qcnt_r <= qcnt_r + {{QAW{1'b0}}, 1'b1};
      else if (pop & ~push)
        qcnt_r <= qcnt_r - {{QAW{1'b0}}, 1'b1};
      // phase 0 pops, phases 1 and 2 hand out the two bytes
      if (rd_queue & ~auto_inc) begin
        if (phase_r == 2'h0)
          phase_r <= pop ? 2'h1 : 2'h0;
        else
          phase_r <= (phase_r == 2'h2) ? 2'h0 : 2'h2;
      end
    end
  end

  // read channel; the queue port stays put for repeated reads
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `APSF_RESP_OKAY;
      last_rd_r <= 8'h00;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `APSF_RESP_OKAY;
        // a pop leaves the next read pointing at the queue again
        last_rd_r <= (rd_idx == `APSF_QUEUE_OFF) ? `APSF_QUEUE_OFF : rd_idx;
        case (rd_idx)
          `APSF_TIMING_OFF: s_axi_rdata <= {24'h0, timing_r};
          `APSF_OPCTL_OFF: s_axi_rdata <= {24'h0, opctl_r};
          `APSF_CHECK_OFF: s_axi_rdata <= {29'h0, check_pass_flag_r, check_complete_flag_r, check_start_r};
          `APSF_RSTKEY_OFF: s_axi_rdata <= 32'h0;
          `APSF_QUEUE_OFF: begin
            if (auto_inc)
              s_axi_rdata <= 32'h0;
            else if (phase_r == 2'h1)
              s_axi_rdata <= {24'h0, word_r[15:8]};
            else if (phase_r == 2'h2)
              s_axi_rdata <= {24'h0, word_r[7:0]};
            else
              s_axi_rdata <= 32'h0;
          end
          `APSF_IRQ_STAT_OFF: s_axi_rdata <= {29'h0, irq_stat_r};
          `APSF_IRQ_MASK_OFF: s_axi_rdata <= {29'h0, irq_mask_r};
          `APSF_QFILL_OFF: s_axi_rdata <= {{(31-QAW){1'b0}}, qcnt_r};
          `APSF_BURST_OFF: s_axi_rdata <= {31'h0, burst_r};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `APSF_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // sticky events: 0 check done, 1 sample queued, 2 queue overflow; set beats clear
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= {`APSF_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else if (soft_rst_r) begin
      irq_stat_r <= {`APSF_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_en & (wr_idx == `APSF_IRQ_STAT_OFF)) ? wbyte[`APSF_IRQ_W-1:0] :
                    {`APSF_IRQ_W{1'b0}})) | {overflow_r, push, check_evt};
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // control outputs registered from the power control byte
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fast_bus_speed_sel <= 1'b0;
      impact_wake_level_sel <= 1'b0;
      antialias_bypass <= 1'b0;
      drift_filter_bypass <= 1'b0;
      op_mode <= 2'h0;
    end else begin
      fast_bus_speed_sel <= opctl_r[`APSF_B_FAST];
      impact_wake_level_sel <= opctl_r[`APSF_B_WAKE];
      antialias_bypass <= opctl_r[`APSF_B_AABYP];
      drift_filter_bypass <= opctl_r[`APSF_B_DRBYP];
      op_mode <= opctl_r[`APSF_MODE_MSB:0];
    end
  end

endmodule

// File: verif/apsf_ctrl_asserts.sv
`timescale 1ns/100ps
module apsf_ctrl_asserts #(
  parameter SETTLE_SHORT_CYC = 10
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // block outputs
  input wire logic [1:0] op_mode,
  input wire logic filter_settled,
  input wire logic sample_strobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  int run_r;
  // cycles out of standby, saturating so it cannot wrap
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) run_r <= 0;
    else if (op_mode == 2'h0) run_r <= 0;
    else if (run_r < 100000) run_r <= run_r + 1;
  end
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // both halves are parked for one cycle before the response goes out
  chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read upper bits set");
  chk_busy_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  chk_busy_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answering");
  chk_standby_idle: assert property (op_mode == 2'h0 ##1 op_mode == 2'h0 |-> !filter_settled)
    else $error("settled in standby");
  chk_settle_floor: assert property ($rose(filter_settled) |-> run_r >= SETTLE_SHORT_CYC - 2)
    else $error("settled too early");
  chk_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
    else $error("strobe wider than a cycle");
endmodule

// File: verif/apsf_far_model.sv
`timescale 1ns/100ps
module apsf_far_model #(
  parameter logic [15:0] WORD = 16'ha5c3
) (
  // control from bench
  input wire logic run_a,
  input wire logic fire_b,
  // pins toward the block
  output logic irq_pin_a,
  output logic irq_pin_b,
  output logic [15:0] sample_data
);
  assign sample_data = WORD;
  // timebase stands still at 0 unless enabled; offset keeps it off the clock edge
  initial begin
    irq_pin_a = 1'b0;
    #7;
    forever begin
      #160;
      irq_pin_a = run_a ? ~irq_pin_a : 1'b0;
    end
  end
  // one trigger pulse, long enough for the synchroniser
  initial begin
    irq_pin_b = 1'b0;
    forever begin
      @(posedge fire_b);
      irq_pin_b = 1'b1;
      #200;
      irq_pin_b = 1'b0;
    end
  end
endmodule

// File: verif/tb.sv
`timescale 1ns/100ps
module tb;
  localparam logic [15:0] WORD = 16'ha5c3;
  logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready, run_a, fire_b;
  logic [8:0] awaddr, araddr;
  logic [7:0] rd_v;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [1:0] rs;
  wire awready, wready, bvalid, arready, rvalid, pin_a, pin_b, fast, wake, aab, drb, settled, strobe, irq;
  wire [1:0] bresp, rresp, op_mode;
  wire [31:0] rdata;
  wire [15:0] sample;
  int bad_count, tests_run;
  apsf_ctrl #(.SETTLE_LONG_CYC(50), .SETTLE_SHORT_CYC(10)) dut_u (.clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq_pin_a(pin_a), .irq_pin_b(pin_b), .sample_data(sample),
    .fast_bus_speed_sel(fast), .impact_wake_level_sel(wake), .antialias_bypass(aab),
    .drift_filter_bypass(drb), .op_mode(op_mode), .filter_settled(settled), .sample_strobe(strobe), .irq(irq));
  apsf_far_model #(.WORD(WORD)) far_u (.run_a(run_a), .fire_b(fire_b), .irq_pin_a(pin_a),
    .irq_pin_b(pin_b), .sample_data(sample));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task hung;
    bad_count++;
    $display("mismatch wait expected done seen timeout");
    end_sim();
  endtask
  // master write: both channels offered together, bready held until answered
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bit got;
    got = 0;
    @(posedge clock);
    awaddr <= {idx[6:0], 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 60 && !got; n++) begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        rs = bresp;
        got = 1;
      end
    end
    if (!got) hung();
  endtask
  task automatic rd(input logic [7:0] idx);
    bit got;
    got = 0;
    @(posedge clock);
    araddr <= {idx[6:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 60 && !got; n++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        rd_v = rdata[7:0];
        rs = rresp;
        got = 1;
      end
    end
    if (!got) hung();
  endtask
  task t_reset;
    rd(8'h3f); chk("opctl", rd_v, 8'h00);
    rd(8'h3d); chk("timing", rd_v, 8'h00);
    rd(8'h42); chk("queue empty", rd_v, 8'h00);
    rd(8'h30); chk("unmapped resp", rs, 2'h2);
    $display("test reset done");
  endtask
  task t_opctl;
    wr(8'h3f, 8'hff);
    rd(8'h3f); chk("opctl reserved", rd_v, 8'hbf);
    chk("ctl outs", {fast, wake, aab, drb}, 4'hf);
    wr(8'h3d, 8'hff);
    rd(8'h3d); chk("timing bits", rd_v, 8'h03);
    wr(8'h3d, 8'h00);
    for (int m = 3; m >= 0; m--) begin
      wr(8'h3f, m[7:0]);
      @(posedge clock);
      chk("op_mode", op_mode, m[1:0]);
    end
    chk("ctl outs off", {fast, wake, aab, drb}, 4'h0);
    $display("test opctl done");
  endtask
  task t_check;
    wr(8'h51, 8'h00);
    wr(8'h40, 8'hff);
    for (int n = 0; n < 100; n++) begin
      rd(8'h40);
      if (rd_v[1]) break;
    end
    chk("check result", rd_v, 8'h07);
    repeat (2) @(posedge clock);
    chk("irq masked", irq, 1'b0);
    wr(8'h51, 8'h01);
    repeat (2) @(posedge clock);
    chk("irq raised", irq, 1'b1);
    wr(8'h50, 8'h07);
    repeat (2) @(posedge clock);
    chk("irq cleared", irq, 1'b0);
    $display("test check done");
  endtask
  task t_key;
    wr(8'h3f, 8'h0c);
    wr(8'h41, 8'h11);
    chk("bad key resp", rs, 2'h0);
    rd(8'h3f); chk("bad key", rd_v, 8'h0c);
    wr(8'h41, 8'h52);
    repeat (2) @(posedge clock);
    rd(8'h3f); chk("key reset", rd_v, 8'h00);
    rd(8'h40); chk("key check", rd_v, 8'h00);
    $display("test key done");
  endtask
  // one triggered sample, then strobe wait
  task automatic trig;
    bit seen;
    seen = 0;
    @(posedge clock);
    fire_b <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge clock);
      seen |= strobe;
    end
    fire_b <= 1'b0;
    chk("trigger strobe", seen, 1'b1);
  endtask
  task t_queue;
    wr(8'h3d, 8'h01);
    wr(8'h3f, 8'h03);
    trig();
    rd(8'h42); chk("pop", rd_v, 8'h00);
    rd(8'h42); chk("msb", rd_v, WORD[15:8]);
    rd(8'h42); chk("lsb", rd_v, WORD[7:0]);
    rd(8'h42); chk("empty pop", rd_v, 8'h00);
    trig();
    wr(8'h53, 8'h01);
    rd(8'h41);
    rd(8'h42); chk("burst zero", rd_v, 8'h00);
    wr(8'h53, 8'h00);
    rd(8'h42);
    rd(8'h42); chk("kept word", rd_v, WORD[15:8]);
    wr(8'h3f, 8'h00);
    $display("test queue done");
  endtask
  task automatic t_tbase;
    int cnt;
    cnt = 0;
    wr(8'h3d, 8'h02);
    wr(8'h3f, 8'h03);
    repeat (64) @(posedge clock) cnt += strobe;
    chk("no timebase", cnt, 0);
    run_a <= 1'b1;
    repeat (64) @(posedge clock) cnt += strobe;
    chk("timebase runs", cnt > 0, 1'b1);
    run_a <= 1'b0;
    wr(8'h3f, 8'h00);
    $display("test timebase done");
  endtask
  task automatic settle(input logic [7:0] v, input int lo, input int hi);
    int n;
    wr(8'h3f, 8'h00);
    wr(8'h3f, v);
    for (n = 0; n < 100 && settled !== 1'b1; n++) @(posedge clock);
    chk("settle window", n >= lo && n <= hi, 1'b1);
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, run_a, fire_b} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h1;
    bad_count = 0;
    tests_run = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_opctl();
    t_check();
    t_key();
    t_queue();
    t_tbase();
    settle(8'h13, 6, 14);
    settle(8'h03, 46, 54);
    $display("test settle done");
    end_sim();
  end
endmodule
bind apsf_ctrl apsf_ctrl_asserts #(.SETTLE_SHORT_CYC(SETTLE_SHORT_CYC)) chk_u (.clock(clock), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .op_mode(op_mode), .filter_settled(filter_settled), .sample_strobe(sample_strobe));
